// *** rtl/dsw_pkg.sv ***
// Constants and types for the serial write port of the converter
// Functional notes
// (RULE1) Each frame is held in a sixteen-bit shift register.
// (RULE2) Data is captured on each serial clock falling edge; controller keeps it valid.
// (RULE3) Frame sync is active low; bits are accepted only while it is low; code also takes an edge seen in the same cycle as the sync rise.
// (RULE4) On the sixteenth falling edge the code and mode are updated.
// (RULE5) Frame sync rising before the sixteenth edge aborts the frame.
// (RULE6) Serial clock runs at most 30 MHz; controller must not exceed it.
// (RULE7) Code is eight bits straight binary; 00 zero scale, ff full scale.
// (RULE8) Frame: two ignored, two mode, eight code bits MSB first, four ignored.
// (RULE9) Mode 00 normal, 01 1k pulldown, 10 100k pulldown, 11 high impedance.
// (RULE10) An aborted frame clears the shift register and changes nothing held.
// (RULE11) Reset clears the held code to zero until a full frame arrives.
// (RULE12) After a frame executes, edges are ignored until sync goes high then low.
package dsw_pkg;

    // ==========================================================
    // Frame layout
    localparam int FRAME_BITS    = 16;
    localparam int CODE_BITS     = 8;
    localparam int MODE_BITS     = 2;
    localparam int CNT_BITS      = 4;
    localparam logic [CNT_BITS-1:0] LAST_BIT_IDX = 4'hf;

    typedef enum logic [MODE_BITS-1:0] {
        DSW_MODE_NORMAL = 2'h0,
        DSW_MODE_PD_1K  = 2'h1,
        DSW_MODE_PD_100K = 2'h2,
        DSW_MODE_PD_HIZ = 2'h3
    } dsw_mode_type;

    typedef struct packed {
        logic [1:0]           lead_ignored;
        dsw_mode_type         mode;
        logic [CODE_BITS-1:0] code;
        logic [3:0]           trail_ignored;
    } dsw_frame_type;

    typedef struct packed {
        logic [CODE_BITS-1:0] code;
        dsw_mode_type         mode;
    } dsw_held_type;

    // ==========================================================
    // Reset and full-scale code values
    localparam logic [CODE_BITS-1:0] CODE_RESET = 8'h00;
    localparam logic [CODE_BITS-1:0] CODE_FULL  = 8'hff;

    // ==========================================================
    // Timing
    localparam int CLK_FREQ_MHZ        = 250;
    localparam int SCLK_MAX_MHZ        = 30;
    localparam int SCLK_MIN_PERIOD_NS  = 33;
    // Least time, rounded up to whole system cycles
    localparam int SCLK_MIN_PERIOD_CYC =
        (SCLK_MIN_PERIOD_NS * CLK_FREQ_MHZ + 999) / 1000;
    localparam int SYNC_STAGES         = 2;

    typedef enum logic [1:0] {
        DSW_IDLE  = 2'b00,
        DSW_SHIFT = 2'b01,
        DSW_DONE  = 2'b11
    } dsw_state_type;

endpackage

// *** rtl/dsw_sync.sv ***
// Two-stage synchroniser for the serial pins
`timescale 1ns/1ps
module dsw_sync #(
    parameter int WIDTH = 3
) (
    input  wire logic             clk,
    input  wire logic             nrst,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] next_stage1;
    logic [WIDTH-1:0] next_sync_out;

    always_comb begin
        next_stage1   = async_in;
        next_sync_out = stage1;
    end

    // Reset to idle levels: clock and frame sync high
    always_ff @(posedge clk) begin
        if (!nrst) begin
            stage1   <= '1;
            sync_out <= '1;
        end else begin
            stage1   <= next_stage1;
            sync_out <= next_sync_out;
        end
    end
endmodule

// *** rtl/dsw_top.sv ***
// Serial write port: frame capture, abort and held code/mode
`timescale 1ns/1ps
module dsw_top
    import dsw_pkg::*;
(
    input  wire logic                    CLK,
    input  wire logic                    NRST,
    input  wire logic                    SCLK,
    input  wire logic                    SYNC_N,
    input  wire logic                    DIN,
    output logic [dsw_pkg::CODE_BITS-1:0] DAC_CODE,
    output dsw_pkg::dsw_mode_type        POWER_MODE,
    output logic                         UPDATE,
    output logic                         FRAME_ABORT
);
    import dsw_pkg::*;

    // ==========================================================
    // Pin synchronisers
    logic [2:0] pins_s;
    logic       sclk_s;
    logic       sync_n_s;
    logic       din_s;

    dsw_sync #(
        .WIDTH (3)
    ) u_sync (
        .clk      (CLK),
        .nrst     (NRST),
        .async_in ({SCLK, SYNC_N, DIN}),
        .sync_out (pins_s)
    );

    assign sclk_s   = pins_s[2];
    assign sync_n_s = pins_s[1];
    assign din_s    = pins_s[0];

    // ==========================================================
    // Falling edge of the serial clock
    logic sclk_d;
    logic next_sclk_d;
    logic fall;

    always_comb begin
        next_sclk_d = sclk_s;
    end

    always_ff @(posedge CLK) begin
        if (!NRST) begin
            sclk_d <= 1'b1;
        end else begin
            sclk_d <= next_sclk_d;
        end
    end

    // Din travels the same two stages, so it stays aligned with the edge
    assign fall = sclk_d & ~sclk_s; // RULE2

    // ==========================================================
    // Frame state machine
    dsw_state_type             state;
    dsw_state_type             next_state;
    logic [FRAME_BITS-1:0]     shreg;
    logic [FRAME_BITS-1:0]     next_shreg;
    logic [CNT_BITS-1:0]       bit_cnt;
    logic [CNT_BITS-1:0]       next_bit_cnt;
    dsw_held_type              held;
    dsw_held_type              next_held;
    logic                      next_update;
    logic                      next_abort;
    dsw_frame_type             frame_in;

    always_comb begin
        frame_in     = dsw_frame_type'({shreg[FRAME_BITS-2:0], din_s}); // RULE8
        next_state   = state;
        next_shreg   = shreg;
        next_bit_cnt = bit_cnt;
        next_held    = held;
        next_update  = 1'b0;
        next_abort   = 1'b0;
        unique case (state)
            DSW_IDLE: begin
                if (!sync_n_s) begin // RULE3
                    next_state   = DSW_SHIFT;
                    next_shreg   = '0;
                    next_bit_cnt = '0;
                    if (fall) begin
                        next_shreg   = {{(FRAME_BITS-1){1'b0}}, din_s};
                        next_bit_cnt = 4'h1;
                    end
                end
            end
            DSW_SHIFT: begin
                // Edge wins over a simultaneous sync rise: zero hold allowed
                if (fall) begin
                    next_shreg   = frame_in; // RULE1
                    next_bit_cnt = bit_cnt + 4'h1;
                    if (bit_cnt == LAST_BIT_IDX) begin // RULE4
                        next_held.code = frame_in.code; // RULE7
                        next_held.mode = frame_in.mode; // RULE9
                        next_update    = 1'b1;
                        next_state     = DSW_DONE;
                    end
                end else if (sync_n_s) begin // RULE5
                    next_shreg   = '0; // RULE10
                    next_bit_cnt = '0;
                    next_abort   = 1'b1;
                    next_state   = DSW_IDLE;
                end
            end
            DSW_DONE: begin
                // Extra edges in an executed frame are dropped
                if (sync_n_s) begin // RULE12
                    next_state   = DSW_IDLE;
                    next_bit_cnt = '0;
                end
            end
            default: begin
                next_state   = DSW_IDLE;
                next_bit_cnt = '0;
            end
        endcase
    end

    always_ff @(posedge CLK) begin
        if (!NRST) begin
            state       <= DSW_IDLE;
            shreg       <= '0;
            bit_cnt     <= '0;
            held.code   <= CODE_RESET; // RULE11
            held.mode   <= DSW_MODE_NORMAL;
            UPDATE      <= 1'b0;
            FRAME_ABORT <= 1'b0;
        end else begin
            state       <= next_state;
            shreg       <= next_shreg;
            bit_cnt     <= next_bit_cnt;
            held        <= next_held;
            UPDATE      <= next_update;
            FRAME_ABORT <= next_abort;
        end
    end

    assign DAC_CODE   = held.code;
    assign POWER_MODE = held.mode;

    // ==========================================================
    // Checks
    // Cycles since the last falling edge, saturating
    logic [7:0] gap;
    logic [7:0] next_gap;
    logic       gap_valid;
    logic       next_gap_valid;

    always_comb begin
        next_gap       = (gap == 8'hff) ? gap : gap + 8'h01;
        next_gap_valid = gap_valid;
        if (fall) begin
            next_gap       = 8'h01;
            next_gap_valid = 1'b1;
        end
    end

    always_ff @(posedge CLK) begin
        if (!NRST) begin
            gap       <= 8'h00;
            gap_valid <= 1'b0;
        end else begin
            gap       <= next_gap;
            gap_valid <= next_gap_valid;
        end
    end

    a_edge_rate: assert property (@(posedge CLK) disable iff (!NRST) // RULE6
        (fall && gap_valid) |-> (gap >= 8'(SCLK_MIN_PERIOD_CYC)))
        else $error("Serial clock faster than allowed");

    a_update_on_last: assert property (@(posedge CLK) disable iff (!NRST) // RULE4
        UPDATE |-> ($past(fall) && $past(bit_cnt) == LAST_BIT_IDX && state == DSW_DONE))
        else $error("Update without sixteenth edge");

    a_update_fields: assert property (@(posedge CLK) disable iff (!NRST) // RULE8
        UPDATE |-> (DAC_CODE == $past(shreg[10:3]) && POWER_MODE == $past(shreg[12:11])))
        else $error("Code or mode taken from wrong frame bits");

    a_code_only_update: assert property (@(posedge CLK) disable iff (!NRST) // RULE10
        (DAC_CODE != $past(DAC_CODE) || POWER_MODE != $past(POWER_MODE)) |-> UPDATE)
        else $error("Held value changed without update");

    a_abort_clears: assert property (@(posedge CLK) disable iff (!NRST) // RULE5
        (state == DSW_SHIFT && sync_n_s && !fall)
            |=> (FRAME_ABORT && shreg == '0 && state == DSW_IDLE && !UPDATE))
        else $error("Abort did not clear the frame");

    a_shift_capture: assert property (@(posedge CLK) disable iff (!NRST) // RULE2
        (state == DSW_SHIFT && fall) |=> (shreg[0] == $past(din_s)
            && bit_cnt == $past(bit_cnt) + 4'h1))
        else $error("Bit not captured on falling edge");

    a_done_ignore: assert property (@(posedge CLK) disable iff (!NRST) // RULE12
        (state == DSW_DONE && !sync_n_s) |=> (state == DSW_DONE && !UPDATE
            && shreg == $past(shreg) && bit_cnt == $past(bit_cnt)))
        else $error("Edges accepted after frame executed");

    a_idle_no_bits: assert property (@(posedge CLK) disable iff (!NRST) // RULE3
        (state == DSW_IDLE && sync_n_s) |=> (bit_cnt == '0 && state == DSW_IDLE))
        else $error("Bits accepted while sync high");

    a_reset_code: assert property (@(posedge CLK) disable iff (!NRST) // RULE11
        $rose(NRST) |-> (DAC_CODE == CODE_RESET && POWER_MODE == DSW_MODE_NORMAL
            && !UPDATE))
        else $error("Held code not zero after reset");

    a_abort_source: assert property (@(posedge CLK) disable iff (!NRST) // RULE5
        FRAME_ABORT |-> ($past(state) == DSW_SHIFT && $past(sync_n_s) && !$past(fall)
            && DAC_CODE == $past(DAC_CODE) && POWER_MODE == $past(POWER_MODE)))
        else $error("Abort without early sync rise");

    a_idle_first_bit: assert property (@(posedge CLK) disable iff (!NRST) // RULE3
        (state == DSW_IDLE && !sync_n_s)
            |=> (state == DSW_SHIFT && bit_cnt == ($past(fall) ? 4'h1 : 4'h0)))
        else $error("Frame not opened on sync low");

endmodule

// *** tb/dsw_host_model.sv ***
// Serial controller model driving the converter write port
`timescale 1ns/1ps
module dsw_host_model (
    input  wire logic clk,
    output logic      sclk,
    output logic      sync_n,
    output logic      din
);
    import dsw_pkg::*;

    initial begin
        sclk   = 1'b1;
        sync_n = 1'b1;
        din    = 1'b0;
    end

    // ==========
    // Frame driver
    // Halves of 20 CLK: 160 ns link period, clock parked high between frames
    task automatic send(input dsw_frame_type f, input int nbits);
        logic [15:0] w;
        w = f;
        @(posedge clk);
        sync_n <= 1'b0;
        for (int i = 0; i < nbits; i++) begin
            din <= (i < 16) ? w[15-i] : ~din;
            repeat (20) @(posedge clk);
            sclk <= 1'b0;
            repeat (20) @(posedge clk);
            sclk <= 1'b1;
        end
        sync_n <= 1'b1;
        // Released line must not keep showing the last bit
        din    <= ~din;
        repeat (12) @(posedge clk);
    endtask
endmodule

// *** tb/tb_dac_serial_write_port.sv ***
// Self-checking bench for the serial write port
`timescale 1ns/1ps
module tb_dac_serial_write_port;
    import dsw_pkg::*;

    logic          clk;
    logic          nrst;
    logic          sclk;
    logic          sync_n;
    logic          din;
    logic [7:0]    dac_code;
    dsw_mode_type  power_mode;
    logic          update;
    logic          frame_abort;
    int            n_fail = 0;
    int            n_tests = 0;
    int            n_upd = 0;
    int            n_abt = 0;
    int            seed;
    int            eu_rst;
    int            ea_rst;
    dsw_held_type  held;
    logic [15:0]   r;

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    dsw_top u_dut (
        .CLK         (clk),
        .NRST        (nrst),
        .SCLK        (sclk),
        .SYNC_N      (sync_n),
        .DIN         (din),
        .DAC_CODE    (dac_code),
        .POWER_MODE  (power_mode),
        .UPDATE      (update),
        .FRAME_ABORT (frame_abort)
    );

    dsw_host_model u_host (
        .clk    (clk),
        .sclk   (sclk),
        .sync_n (sync_n),
        .din    (din)
    );

    always @(posedge clk) begin
        if (update === 1'b1) n_upd <= n_upd + 1;
        if (frame_abort === 1'b1) n_abt <= n_abt + 1;
    end

    // ==========
    // Helpers
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    function automatic dsw_frame_type frame_of(input dsw_mode_type m, input logic [7:0] c);
        logic [15:0] x;
        x = 16'($random(seed));
        return dsw_frame_type'({x[15:14], m, c, x[3:0]});
    endfunction

    function automatic dsw_held_type expect_of(input dsw_frame_type f);
        return '{code: f.code, mode: f.mode};
    endfunction

    task automatic expect_all(input int eu, input int ea);
        check("code", {8'h00, dac_code}, {8'h00, held.code});
        check("mode", {14'h0, power_mode}, {14'h0, held.mode});
        check("updates", n_upd[15:0], eu[15:0]);
        check("aborts", n_abt[15:0], ea[15:0]);
    endtask

    task automatic run_frame(input dsw_frame_type f, input int nbits);
        int eu;
        int ea;
        eu = n_upd + ((nbits >= 16) ? 1 : 0);
        ea = n_abt + ((nbits < 16) ? 1 : 0);
        if (nbits >= 16) held = expect_of(f);
        u_host.send(f, nbits);
        repeat (10) @(posedge clk);
        expect_all(eu, ea);
    endtask

    task automatic print_verdict();
        $display("Checks %0d, mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    // ==========
    // Scenarios
    initial begin
        nrst = 1'b0;
        seed = 52578;
        held = '0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        expect_all(0, 0);
        for (int m = 0; m < 4; m++) begin
            r = 16'($random(seed));
            if (m == 0) r[7:0] = CODE_FULL;
            if (m == 3) r[7:0] = CODE_RESET;
            run_frame(frame_of(dsw_mode_type'(m[1:0]), r[7:0]), 16);
        end
        run_frame(frame_of(DSW_MODE_PD_1K, 8'h5a), 15);
        run_frame(frame_of(DSW_MODE_NORMAL, 8'h81), 1);
        run_frame(frame_of(DSW_MODE_PD_100K, 8'h3c), 20);
        for (int k = 0; k < 12; k++) begin
            r = 16'($random(seed));
            run_frame(frame_of(dsw_mode_type'(r[9:8]), r[7:0]),
                      1 + (r[15:10] % 20));
        end
        // Known non-zero code first, so the reset clear is visible
        run_frame(frame_of(DSW_MODE_PD_1K, CODE_FULL), 16);
        eu_rst = n_upd;
        ea_rst = n_abt;
        nrst <= 1'b0;
        repeat (3) @(posedge clk);
        held = '0;
        expect_all(eu_rst, ea_rst);
        nrst <= 1'b1;
        run_frame(frame_of(DSW_MODE_PD_HIZ, 8'h7f), 16);
        print_verdict();
    end

    initial begin
        #200000;
        n_fail++;
        print_verdict();
    end
endmodule
